// ==== verilog/input_level_control_config.sv ====
// Overview of operation
// RULE1 - Peak-detect recorded samples and steer amp gain toward the target.
// RULE2 - Per-channel loop enables; a disabled channel uses its manual gain.
// RULE3 - Software enables both converters for left, right converter for right.
// RULE4 - Software clears loop enables before turning the converters off.
// RULE5 - Software keeps the loop off while direct inputs feed the mixer.
// RULE6 - Monitor-only 0 drives gain; 1 only measures, no gain change.
// RULE7 - Software sets at least one channel enable for the mode to matter.
// RULE8 - Range select picks low ladder from -28.5 or high from -22.5 dBFS.
// RULE9 - Four-bit target code, reset 1011, 1.5 dB per step from the bottom.
// RULE10 - High range codes 1110 and 1111 both give -1.5 dBFS.
// RULE11 - Software equalises left and right gains before stereo enable.
// RULE12 - Noise gate keeps the path quiet when no signal is present; here it only flags silence and holds the gain while tracking.
// RULE13 - Limiter mode only cuts peaks, never raising gain past its start.
// RULE14 - Clearing an enable returns the gain to the manual field next update.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module input_level_control_config
	import level_control_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [level_control_pkg::SAMPLE_W-1:0] sample_left,
	input wire logic [level_control_pkg::SAMPLE_W-1:0] sample_right,
	input wire logic sample_valid,
	output logic [level_control_pkg::GAIN_W-1:0] left_amp_gain,
	output logic [level_control_pkg::GAIN_W-1:0] right_amp_gain,
	output logic noise_gate_active
);
	import level_control_pkg::*;

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	logic left_loop_enable;
	logic right_loop_enable;
	logic monitor_only_select;
	logic target_range_select;
	logic [3:0] target_level_code;
	logic limiter_mode_select;
	logic [GAIN_W-1:0] left_amp_manual_gain;
	logic [GAIN_W-1:0] right_amp_manual_gain;

	// ----------------------------------------
	// Loop state
	// ----------------------------------------
	loop_state_t state;
	loop_state_t next_state;
	logic [GAIN_W-1:0] start_left;
	logic [GAIN_W-1:0] start_right;
	logic left_enable_prev;
	logic right_enable_prev;
	logic [15:0] peak_left;
	logic [15:0] peak_right;
	logic peak_done;
	logic [15:0] threshold;
	logic [15:0] peak_used_left;
	logic [15:0] peak_used_right;
	logic [15:0] peak_stereo;
	logic stereo;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic request;
	logic write_now;
	logic [5:0] index;
	logic [31:0] read_value;

	assign request = avs_read || avs_write;
	assign index = avs_address[7:2];
	// A write lands only on the edge that sees waitrequest low
	assign write_now = clk_en && avs_write && !avs_waitrequest;

	// ----------------------------------------
	// Peak detection and target ladder
	// ----------------------------------------
	peak_window_detector peak_unit (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.sample_left(sample_left),
		.sample_right(sample_right),
		.sample_valid(sample_valid),
		.peak_left(peak_left),
		.peak_right(peak_right),
		.peak_done(peak_done)
	);

	// RULE8 range selects ladder
	target_level_lookup target_unit (
		.target_code(target_level_code),
		.high_range(target_range_select),
		.threshold(threshold)
	);

	// ----------------------------------------
	// Gain step
	// ----------------------------------------
	function automatic logic [GAIN_W-1:0] step_gain(
		input logic [GAIN_W-1:0] gain,
		input logic [15:0] peak,
		input logic [15:0] target,
		input logic limiter,
		input logic [GAIN_W-1:0] start
	);
		logic [GAIN_W-1:0] result;
		result = gain;
		if (peak > target) begin
			if (gain != GAIN_MIN)
				result = gain - 6'h01;
		end else if (peak < GATE_LEVEL) begin
			// Silence: raising gain would only lift the noise floor
			result = gain;
		end else if (peak < target) begin
			// RULE13 limiter caps at start gain
			if (gain != GAIN_MAX && (!limiter || gain < start))
				result = gain + 6'h01;
		end
		step_gain = result;
	endfunction

	// In stereo the louder channel drives both so the image holds
	assign stereo = left_loop_enable && right_loop_enable;
	assign peak_stereo = peak_left > peak_right ? peak_left : peak_right;
	assign peak_used_left = stereo ? peak_stereo : peak_left;
	assign peak_used_right = stereo ? peak_stereo : peak_right;

	// ----------------------------------------
	// Loop state machine
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			LOOP_OFF: begin
				if (left_loop_enable || right_loop_enable)
					next_state = monitor_only_select ?
						LOOP_MONITOR : LOOP_TRACK;
			end
			LOOP_TRACK: begin
				if (!left_loop_enable && !right_loop_enable)
					next_state = LOOP_OFF;
				else if (monitor_only_select)
					next_state = LOOP_MONITOR;
			end
			LOOP_MONITOR: begin
				if (!left_loop_enable && !right_loop_enable)
					next_state = LOOP_OFF;
				else if (!monitor_only_select)
					next_state = LOOP_TRACK;
			end
			default: next_state = LOOP_OFF;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			state <= LOOP_OFF;
		else if (clk_en)
			state <= next_state;
	end

	// ----------------------------------------
	// Starting gain capture
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			left_enable_prev <= 1'b0;
			right_enable_prev <= 1'b0;
			start_left <= MANUAL_GAIN_RESET;
			start_right <= MANUAL_GAIN_RESET;
		end else if (clk_en) begin
			left_enable_prev <= left_loop_enable;
			right_enable_prev <= right_loop_enable;
			if (left_loop_enable && !left_enable_prev)
				start_left <= left_amp_manual_gain;
			if (right_loop_enable && !right_enable_prev)
				start_right <= right_amp_manual_gain;
		end
	end

	// ----------------------------------------
	// Amplifier gain outputs
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			left_amp_gain <= MANUAL_GAIN_RESET;
		end else if (clk_en) begin
			// RULE2 disabled follows manual
			// RULE14 hand back on clear
			if (!left_loop_enable || !left_enable_prev)
				left_amp_gain <= left_amp_manual_gain;
			// RULE6 monitor holds manual gain
			// Select, not state, so the hold starts one edge after the write
			else if (monitor_only_select)
				left_amp_gain <= left_amp_manual_gain;
			// RULE1 loop steers gain
			else if (state == LOOP_TRACK && peak_done)
				left_amp_gain <= step_gain(left_amp_gain, peak_used_left,
					threshold, limiter_mode_select, start_left);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			right_amp_gain <= MANUAL_GAIN_RESET;
		end else if (clk_en) begin
			// RULE2 disabled follows manual
			// RULE14 hand back on clear
			if (!right_loop_enable || !right_enable_prev)
				right_amp_gain <= right_amp_manual_gain;
			// RULE6 monitor holds manual gain
			else if (monitor_only_select)
				right_amp_gain <= right_amp_manual_gain;
			// RULE1 loop steers gain
			else if (state == LOOP_TRACK && peak_done)
				right_amp_gain <= step_gain(right_amp_gain,
					peak_used_right, threshold, limiter_mode_select,
					start_right);
		end
	end

	// ----------------------------------------
	// Noise gate
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			noise_gate_active <= 1'b0;
		end else if (clk_en) begin
			// RULE12 gate on silence
			if (state != LOOP_TRACK)
				noise_gate_active <= 1'b0;
			else if (peak_done)
				noise_gate_active <=
					(!left_loop_enable || peak_used_left < GATE_LEVEL) &&
					(!right_loop_enable || peak_used_right < GATE_LEVEL);
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			monitor_only_select <= MONITOR_ONLY_RESET;
			target_range_select <= TARGET_RANGE_RESET;
			left_loop_enable <= ENABLE_RESET;
			right_loop_enable <= ENABLE_RESET;
			target_level_code <= TARGET_CODE_RESET;
		end else if (write_now && index == IDX_CONFIG_ONE) begin
			if (avs_byteenable[1]) begin
				monitor_only_select <= avs_writedata[MONITOR_ONLY_BIT];
				target_range_select <= avs_writedata[TARGET_RANGE_BIT];
				left_loop_enable <= avs_writedata[LEFT_ENABLE_BIT];
			end
			if (avs_byteenable[0]) begin
				right_loop_enable <= avs_writedata[RIGHT_ENABLE_BIT];
				target_level_code <= avs_writedata[TARGET_CODE_MSB:0];
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			limiter_mode_select <= LIMITER_MODE_RESET;
		else if (write_now && index == IDX_LOOP_MODE &&
			avs_byteenable[1])
			limiter_mode_select <= avs_writedata[LIMITER_MODE_BIT];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			left_amp_manual_gain <= MANUAL_GAIN_RESET;
			right_amp_manual_gain <= MANUAL_GAIN_RESET;
		end else if (write_now && avs_byteenable[0]) begin
			if (index == IDX_MANUAL_LEFT)
				left_amp_manual_gain <= avs_writedata[GAIN_W-1:0];
			if (index == IDX_MANUAL_RIGHT)
				right_amp_manual_gain <= avs_writedata[GAIN_W-1:0];
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always_comb begin
		read_value = 32'h0000_0000;
		case (index)
			IDX_CONFIG_ONE: begin
				read_value[MONITOR_ONLY_BIT] = monitor_only_select;
				read_value[TARGET_RANGE_BIT] = target_range_select;
				read_value[LEFT_ENABLE_BIT] = left_loop_enable;
				read_value[RIGHT_ENABLE_BIT] = right_loop_enable;
				read_value[TARGET_CODE_MSB:0] = target_level_code;
			end
			IDX_LOOP_MODE:
				read_value[LIMITER_MODE_BIT] = limiter_mode_select;
			IDX_MANUAL_LEFT:
				read_value[GAIN_W-1:0] = left_amp_manual_gain;
			IDX_MANUAL_RIGHT:
				read_value[GAIN_W-1:0] = right_amp_manual_gain;
			IDX_LOOP_STATUS: begin
				read_value[5:0] = left_amp_gain;
				read_value[13:8] = right_amp_gain;
				read_value[16] = noise_gate_active;
				read_value[25:24] = state;
			end
			IDX_PEAK_LEVEL:
				read_value = {peak_right, peak_left};
			default: read_value = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Handshake: one wait cycle, then one ready cycle
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (request && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				if (avs_read)
					avs_readdata <= read_value;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

endmodule

// ==== verilog/level_control_pkg.sv ====
package level_control_pkg;

	// ----------------------------------------
	// Register indexes (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0] IDX_CONFIG_ONE = 6'h11;
	localparam logic [5:0] IDX_LOOP_MODE = 6'h13;
	localparam logic [5:0] IDX_MANUAL_LEFT = 6'h01;
	localparam logic [5:0] IDX_MANUAL_RIGHT = 6'h02;
	localparam logic [5:0] IDX_LOOP_STATUS = 6'h30;
	localparam logic [5:0] IDX_PEAK_LEVEL = 6'h31;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MONITOR_ONLY_BIT = 10;
	localparam int TARGET_RANGE_BIT = 9;
	localparam int LEFT_ENABLE_BIT = 8;
	localparam int RIGHT_ENABLE_BIT = 7;
	localparam int TARGET_CODE_MSB = 3;
	localparam int LIMITER_MODE_BIT = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0] TARGET_CODE_RESET = 4'hb;
	localparam logic TARGET_RANGE_RESET = 1'b0;
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic MONITOR_ONLY_RESET = 1'b0;
	localparam logic LIMITER_MODE_RESET = 1'b0;
	localparam logic [5:0] MANUAL_GAIN_RESET = 6'h10;

	// ----------------------------------------
	// Widths, levels and timing
	// ----------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int GAIN_W = 6;
	localparam logic [5:0] GAIN_MAX = 6'h3f;
	localparam logic [5:0] GAIN_MIN = 6'h00;
	localparam logic [7:0] PEAK_WINDOW = 8'h40;
	localparam logic [15:0] GATE_LEVEL = 16'h0040;
	localparam logic [15:0] FULL_SCALE = 16'h7fff;
	// Target ladder: 1.5 dB per index, index 0 is -28.5 dBFS
	localparam real TARGET_BASE_DBFS = -28.5;
	localparam real TARGET_STEP_DB = 1.5;
	localparam logic [4:0] HIGH_RANGE_OFFSET = 5'h04;
	localparam logic [4:0] TARGET_TOP_INDEX = 5'h12;

	typedef enum logic [1:0] {
		LOOP_OFF = 2'b00,
		LOOP_TRACK = 2'b01,
		LOOP_MONITOR = 2'b11
	} loop_state_t;

endpackage

// ==== verilog/target_level_lookup.sv ====
`timescale 1ns/1ps
module target_level_lookup
	import level_control_pkg::*;
(
	input wire logic [3:0] target_code,
	input wire logic high_range,
	output logic [15:0] threshold
);

	// ----------------------------------------
	// Linear thresholds of the 1.5 dB ladder
	// ----------------------------------------
	function automatic logic [15:0] ladder(input logic [4:0] idx);
		case (idx)
			5'h00: ladder = 16'h04cf;
			5'h01: ladder = 16'h05b8;
			5'h02: ladder = 16'h06cc;
			5'h03: ladder = 16'h0814;
			5'h04: ladder = 16'h0999;
			5'h05: ladder = 16'h0b68;
			5'h06: ladder = 16'h0d8f;
			5'h07: ladder = 16'h101d;
			5'h08: ladder = 16'h1327;
			5'h09: ladder = 16'h16c3;
			5'h0a: ladder = 16'h1b0d;
			5'h0b: ladder = 16'h2027;
			5'h0c: ladder = 16'h2636;
			5'h0d: ladder = 16'h2d6b;
			5'h0e: ladder = 16'h35fa;
			5'h0f: ladder = 16'h4026;
			5'h10: ladder = 16'h4c3e;
			5'h11: ladder = 16'h5a9d;
			default: ladder = 16'h6bb2;
		endcase
	endfunction

	logic [4:0] raw_index;
	logic [4:0] index;

	assign raw_index = {1'b0, target_code} +
		(high_range ? HIGH_RANGE_OFFSET : 5'h00);
	// RULE10 high range saturates
	assign index = (raw_index > TARGET_TOP_INDEX) ?
		TARGET_TOP_INDEX : raw_index;
	// RULE9 code to level
	assign threshold = ladder(index);

endmodule

// ==== verilog/peak_window_detector.sv ====
`timescale 1ns/1ps
module peak_window_detector
	import level_control_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [15:0] sample_left,
	input wire logic [15:0] sample_right,
	input wire logic sample_valid,
	output logic [15:0] peak_left,
	output logic [15:0] peak_right,
	output logic peak_done
);

	// Magnitude; the most negative code is clipped to full scale
	function automatic logic [15:0] magnitude(input logic [15:0] s);
		if (s == 16'h8000)
			magnitude = FULL_SCALE;
		else if (s[15])
			magnitude = 16'(~s + 16'h0001);
		else
			magnitude = s;
	endfunction

	logic [15:0] run_left;
	logic [15:0] run_right;
	logic [7:0] count;
	logic [15:0] mag_left;
	logic [15:0] mag_right;
	logic window_end;

	assign mag_left = magnitude(sample_left);
	assign mag_right = magnitude(sample_right);
	assign window_end = sample_valid && (count == PEAK_WINDOW - 8'h01);

	// RULE1 peak detection
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			run_left <= 16'h0000;
			run_right <= 16'h0000;
			count <= 8'h00;
		end else if (clk_en && sample_valid) begin
			count <= window_end ? 8'h00 : count + 8'h01;
			run_left <= window_end ? 16'h0000 :
				(mag_left > run_left ? mag_left : run_left);
			run_right <= window_end ? 16'h0000 :
				(mag_right > run_right ? mag_right : run_right);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			peak_left <= 16'h0000;
			peak_right <= 16'h0000;
			peak_done <= 1'b0;
		end else if (clk_en) begin
			peak_done <= window_end;
			if (window_end) begin
				peak_left <= mag_left > run_left ? mag_left : run_left;
				peak_right <= mag_right > run_right ? mag_right : run_right;
			end
		end
	end

endmodule

// ==== bench/input_level_control_config_asserts.sv ====
`timescale 1ns/1ps
module input_level_control_config_asserts
	import level_control_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic sample_valid,
	input wire logic [level_control_pkg::GAIN_W-1:0] left_amp_gain,
	input wire logic [level_control_pkg::GAIN_W-1:0] right_amp_gain,
	input wire logic noise_gate_active
);
	// ----
	// Shadow of the writable fields, except the right manual gain
	// ----
	logic [15:0] cfg;
	logic [5:0] man_l;
	logic [5:0] start_l;
	logic lim;
	logic wr_ok;
	logic [5:0] idx;
	logic trk_l;
	logic trk_r;
	assign wr_ok = avs_write && !avs_waitrequest && clk_en;
	assign idx = avs_address[7:2];
	assign trk_l = cfg[8] && !cfg[10];
	assign trk_r = cfg[7] && !cfg[10];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg <= 16'h000b;
			man_l <= 6'h10;
			lim <= 1'b0;
		end else if (wr_ok) begin
			if (idx == IDX_CONFIG_ONE && avs_byteenable[0]) begin
				cfg[7:0] <= avs_writedata[7:0] & 8'h8f;
			end
			if (idx == IDX_CONFIG_ONE && avs_byteenable[1]) begin
				cfg[15:8] <= avs_writedata[15:8] & 8'h07;
			end
			if (idx == IDX_MANUAL_LEFT && avs_byteenable[0]) begin
				man_l <= avs_writedata[5:0];
			end
			if (idx == IDX_LOOP_MODE && avs_byteenable[1]) begin
				lim <= avs_writedata[8];
			end
		end
	end
	// Start gain is the manual value held up to the enable edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			start_l <= 6'h10;
		end else if (!cfg[8]) begin
			start_l <= man_l;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	property p_left_manual;
		!cfg[8] && !$past(cfg[8]) |-> left_amp_gain == $past(man_l);
	endproperty
	a_left_manual: assert property (p_left_manual)
		else $error("left gain not following manual field");
	property p_monitor;
		cfg[10] && $past(cfg[10]) && cfg[8] |-> left_amp_gain == $past(man_l);
	endproperty
	a_monitor: assert property (p_monitor)
		else $error("gain moved in monitor mode");
	property p_step;
		trk_r && $past(trk_r) && $past(trk_r, 2)
			|-> 6'(right_amp_gain - $past(right_amp_gain)) inside
			{6'h00, 6'h01, 6'h3f};
	endproperty
	a_step: assert property (p_step)
		else $error("right gain stepped by more than one");
	property p_window;
		trk_l && $past(trk_l) && $past(trk_l, 2)
			&& left_amp_gain != $past(left_amp_gain)
			|-> $past(sample_valid, 2) || $past(sample_valid, 3)
			|| $past(sample_valid, 4);
	endproperty
	a_window: assert property (p_window)
		else $error("left gain changed without a window end");
	property p_gate_off;
		!(trk_l || trk_r) && !$past(trk_l || trk_r)
			&& !$past(trk_l || trk_r, 2) |-> !noise_gate_active;
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("gate flag high outside tracking");
	property p_gate_rise;
		$rose(noise_gate_active) |-> $past(sample_valid, 2)
			|| $past(sample_valid, 3) || $past(sample_valid, 4);
	endproperty
	a_gate_rise: assert property (p_gate_rise)
		else $error("gate flag rose without a window end");
	property p_limiter;
		lim && trk_l && $past(trk_l) |-> left_amp_gain <= start_l;
	endproperty
	a_limiter: assert property (p_limiter)
		else $error("limiter raised gain above start");
	property p_readback;
		avs_read && !avs_waitrequest && idx == IDX_CONFIG_ONE
			|-> avs_readdata == {16'h0000, cfg};
	endproperty
	a_readback: assert property (p_readback)
		else $error("config readback wrong");
endmodule
bind input_level_control_config input_level_control_config_asserts
	u_input_level_control_config_asserts (
	.core_clk, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.sample_valid, .left_amp_gain, .right_amp_gain, .noise_gate_active
);

// ==== bench/input_level_control_config_test.sv ====
`timescale 1ns/1ps
module input_level_control_config_test;
	import level_control_pkg::*;
	logic core_clk;
	logic rst;
	logic clk_en;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] sample_left;
	logic [15:0] sample_right;
	logic sample_valid;
	logic [5:0] left_amp_gain;
	logic [5:0] right_amp_gain;
	logic noise_gate_active;
	logic [31:0] rd;
	logic [31:0] d;
	int error_cnt;
	int checked;
	int thr[19] = '{'h4cf, 'h5b8, 'h6cc, 'h814, 'h999, 'hb68, 'hd8f,
		'h101d, 'h1327, 'h16c3, 'h1b0d, 'h2027, 'h2636, 'h2d6b, 'h35fa,
		'h4026, 'h4c3e, 'h5a9d, 'h6bb2};

	input_level_control_config u_input_level_control_config (
		.core_clk, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.sample_left, .sample_right, .sample_valid, .left_amp_gain,
		.right_amp_gain, .noise_gate_active
	);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// ----
	// Shared tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, input logic [3:0] be);
		@(posedge core_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge core_clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// Every sample stays within pk, the last one reaches it
	task automatic window(input int pk);
		int m;
		for (int i = 0; i < 64; i++) begin
			@(posedge core_clk);
			m = (i == 63) ? pk : $urandom_range(pk);
			sample_left <= $urandom_range(1) ? 16'(m) : 16'(-m);
			m = (i == 63) ? pk : $urandom_range(pk);
			sample_right <= $urandom_range(1) ? 16'(m) : 16'(-m);
			sample_valid <= 1'b1;
		end
		@(posedge core_clk);
		sample_valid <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask
	// Rule model: one window's gain step for a tracking channel
	function automatic int model_gain(input int g, input int pk,
		input int t, input int lim, input int st);
		if (pk > t)
			return (g > 0) ? g - 1 : g;
		if (pk < 'h40 || pk == t)
			return g;
		return (g < 63 && (lim == 0 || g < st)) ? g + 1 : g;
	endfunction
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		int g;
		int ix;
		int ch;
		int mg;
		rst = 1'b1;
		clk_en = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		sample_left = 16'h0;
		sample_right = 16'h0;
		sample_valid = 1'b0;
		void'($urandom(47));
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		bus(0, 8'h44, 0, 4'hf);
		check(rd, 32'h0000000b);
		check(left_amp_gain, 32'h10);
		bus(0, 8'hfc, 0, 4'hf);
		check(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			bus(1, 8'h44, d, 4'hf);
			bus(0, 8'h44, 0, 4'hf);
			check(rd, d & 32'h78f);
		end
		bus(1, 8'h44, 32'hffff, 4'h1);
		bus(0, 8'h44, 0, 4'hf);
		check(rd, (d & 32'h700) | 32'h8f);
		bus(1, 8'h44, 0, 4'hf);
		for (int i = 0; i < 4; i++) begin
			g = $urandom_range(63);
			bus(1, 8'h04, g, 4'hf);
			bus(1, 8'h08, 63 - g, 4'hf);
			repeat (2) @(posedge core_clk);
			check({left_amp_gain, right_amp_gain}, (g << 6) | (63 - g));
		end
		$display("register test done");
		// equal gains before any stereo enable
		bus(1, 8'h04, 32'h20, 4'hf);
		bus(1, 8'h08, 32'h20, 4'hf);
		for (int r = 0; r < 2; r++) begin
			for (int c = 0; c < 16; c++) begin
				ix = (c + 4 * r > 18) ? 18 : c + 4 * r;
				ch = c % 2;
				bus(1, 8'h44, (r << 9) | (1 << (8 - ch)) | c, 4'hf);
				mg = model_gain(32, thr[ix] + 1, thr[ix], 0, 32);
				window(thr[ix] + 1);
				check(ch ? right_amp_gain : left_amp_gain, mg);
				check(ch ? left_amp_gain : right_amp_gain, 32'h20);
				mg = model_gain(mg, thr[ix] - 1, thr[ix], 0, 32);
				window(thr[ix] - 1);
				check(ch ? right_amp_gain : left_amp_gain, mg);
				bus(1, 8'h44, 0, 4'hf);
			end
		end
		$display("target test done");
		bus(1, 8'h44, 32'h100, 4'hf);
		window(32'h20);
		check({noise_gate_active, left_amp_gain}, 32'h60);
		bus(0, 8'hc0, 0, 4'hf);
		check(rd, 32'h0101_2020);
		bus(0, 8'hc4, 0, 4'hf);
		check(rd, 32'h0020_0020);
		window(32'h7fff);
		check({noise_gate_active, left_amp_gain}, 32'h1f);
		bus(1, 8'h44, 0, 4'hf);
		repeat (2) @(posedge core_clk);
		check(left_amp_gain, 32'h20);
		bus(1, 8'h44, 32'h580, 4'hf);
		window(32'h8000);
		check({noise_gate_active, left_amp_gain, right_amp_gain}, 32'h820);
		bus(0, 8'hc4, 0, 4'hf);
		check(rd, 32'h7fff_7fff);
		bus(0, 8'hc0, 0, 4'hf);
		check(rd, 32'h0300_2020);
		$display("gate and monitor test done");
		bus(1, 8'h44, 0, 4'hf);
		bus(1, 8'h4c, 32'h100, 4'hf);
		bus(0, 8'h4c, 0, 4'hf);
		check(rd, 32'h100);
		bus(1, 8'h44, 32'h10f, 4'hf);
		mg = 32;
		for (int i = 0; i < 4; i++) begin
			g = (i == 1) ? 'h7fff : 'h100;
			mg = model_gain(mg, g, thr[15], 1, 32);
			window(g);
			check(left_amp_gain, mg);
		end
		$display("limiter test done");
		stop_test;
	end

	initial begin
		#2000000;
		error_cnt++;
		$display("unexpected at %0t: run timed out", $time);
		stop_test;
	end
endmodule
